// *** inc/rssq_params.svh ***
// Purpose : timing counts and fixed values for the reset/stop sequencer
// Assumes : 40 MHz system clock, oscillator cycles arrive as enable ticks
// Notes   : included by the package, the design file and the bench
`ifndef RSSQ_PARAMS_SVH
`define RSSQ_PARAMS_SVH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define RSSQ_CLK_PERIOD_NS     25
`define RSSQ_OSC_START_NS      4000
`define RSSQ_OSC_START_CYC     ((`RSSQ_OSC_START_NS + `RSSQ_CLK_PERIOD_NS - 1) / `RSSQ_CLK_PERIOD_NS)
`define RSSQ_HOLD_SHORT        66
`define RSSQ_HOLD_LONG         5000

// ----------------------------------------------------------------------
// reset vector, register offsets, register reset values and bit positions
// ----------------------------------------------------------------------
`define RSSQ_VEC_HI_ADDR       16'h0002
`define RSSQ_VEC_LO_ADDR       16'h0003
`define RSSQ_REG_CTRL          4'h0
`define RSSQ_REG_STATUS        4'h4
`define RSSQ_REG_WATCHDOG_CONTROL_REG       4'h8
`define RSSQ_REG_OSCILLATOR_CONTROL_REG       4'hc
`define RSSQ_WATCHDOG_CONTROL_REG_RESET     8'h00
`define RSSQ_OSCILLATOR_CONTROL_REG_RESET     8'h20
`define RSSQ_PWR_CTL_RESET     8'h00
`define RSSQ_OSC_WDT_EN_BIT    5
`define RSSQ_PWR_AMP_EN_BIT    4
`define RSSQ_WDT_EN_BIT        7

`endif

// *** inc/rssq_pkg.sv ***
// Purpose : types for the reset/stop sequencer
// Assumes : nothing beyond the parameter header
// Notes   : none
package rssq_pkg;
  `include "rssq_params.svh"

  typedef enum logic [2:0] {
    RSSQ_ST_OSC_START,
    RSSQ_ST_HOLD,
    RSSQ_ST_PIN_WAIT,
    RSSQ_ST_VEC_HI,
    RSSQ_ST_VEC_LO,
    RSSQ_ST_ACTIVE,
    RSSQ_ST_HALT,
    RSSQ_ST_STOP
  } rssq_state_t;

  // power enables that go to the rest of the chip
  typedef struct packed {
    logic core_run;
    logic periph_run;
    logic ipo_run;
    logic xtal_run;
    logic wdt_osc_run;
    logic wdt_run;
    logic brownout_run;
    logic amp_run;
  } rssq_power_t;

  // program memory fetch of the reset vector
  typedef struct packed {
    logic        req;
    logic [15:0] addr;
  } rssq_fetch_t;
endpackage

// *** design/rssq_sequencer.sv ***
// Purpose : reset hold, reset vector fetch and STOP/HALT sequencing
// Assumes : ipo_tick pulses once per internal oscillator cycle
// Notes   : control bits reached over Avalon-MM, one word per register
`timescale 1ns/100ps
`include "rssq_params.svh"

// Overview of operation
// - after reset or stop recovery wait oscillator start, then hold 66 cycles
// - crystal option bit stretches the hold to 5000 oscillator cycles
// - supply-detected resets start counting once supply is reported good
// - hold continues while the external reset pin stays asserted
// - reset makes general pins inputs with pull-ups off, except reset pin
// - shared reset pin is open-drain reset, driven low during port reset
// - core and peripherals idle in reset; crystal and watchdog osc run
// - registers with a defined reset value are reloaded on reset
// - core reads vector from bytes 0002H and 0003H into program counter
// - system clock after reset is internal oscillator; software reselects
// - stop recovery resets core, reinitialises only watchdog and osc control
// - stop instruction enters STOP; brownout, amp, watchdog may stay on
// - in STOP both oscillators stop and crystal pins revert to port
// - in STOP system clock and core halt, program counter frozen
// - watchdog oscillator and logic run in STOP when enabled
// - brownout stays active in STOP only when its option bit allows
// - amplifier runs in STOP only if power control enables it
// - HALT powers down only the core
// - STOP is left only through stop recovery or a new supply or low-voltage reset
// - active means neither STOP nor HALT; blocks disabled separately
module rssq_sequencer
  import rssq_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        ipo_tick,
  input  wire logic        supply_good,
  input  wire logic        low_voltage_reset,
  input  wire logic        reset_pin_in,
  input  wire logic        opt_xtal_enable,
  input  wire logic        opt_brownout_in_stop,
  input  wire logic        stop_instr,
  input  wire logic        halt_instr,
  input  wire logic        wake_event,
  input  wire logic        interrupt_event,
  input  wire logic [7:0]  prog_data,
  input  wire logic        prog_valid,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             avs_response_err,
  output rssq_fetch_t      fetch,
  output logic      [15:0] pc_load_value,
  output logic             pc_load,
  output logic             core_reset,
  output logic             periph_reset,
  output logic             gpio_reset,
  output logic             reset_pin_out,
  output logic             reset_pin_oe,
  output logic             crystal_pins_to_port,
  output logic             sysclk_is_ipo,
  output rssq_power_t      power
);

  // ----------------------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------------------
  rssq_state_t state;
  rssq_state_t next_state;
  logic [12:0] hold_count;
  logic [12:0] next_hold_count;
  logic [7:0]  start_count;
  logic [7:0]  next_start_count;
  logic [7:0]  vec_hi;
  logic        from_stop;
  logic        pin_reset_mode;
  logic [7:0]  watchdog_control_reg;
  logic [7:0]  oscillator_control_reg;
  logic [7:0]  power_control_reg;
  logic        sw_clk_select;
  logic        bus_ack;

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  // a fresh supply or low-voltage reset; restarts the hold count
  // outside the reset states it also pulls an active or halted core back
  wire   new_source   = low_voltage_reset | ~supply_good;
  // the option bit is read live; it is expected to stay put during a hold
  wire   hold_limit_w = opt_xtal_enable;
  wire   [12:0] hold_target = hold_limit_w ? 13'(`RSSQ_HOLD_LONG - 1)
                                           : 13'(`RSSQ_HOLD_SHORT - 1);
  wire   in_reset     = (state == RSSQ_ST_OSC_START) |
                        (state == RSSQ_ST_HOLD) |
                        (state == RSSQ_ST_PIN_WAIT);
  wire   in_stop      = (state == RSSQ_ST_STOP);
  wire   in_halt      = (state == RSSQ_ST_HALT);
  // the pin is pulled low only while the port itself is in reset; it must
  // be let go before the pin-release wait, or the device would see its own
  // drive as an asserted external reset and never leave the hold
  wire   port_reset   = (state == RSSQ_ST_OSC_START) |
                        (state == RSSQ_ST_HOLD);
  wire   bus_req      = avs_read | avs_write;
  wire   addr_ok      = (avs_address == `RSSQ_REG_CTRL) |
                        (avs_address == `RSSQ_REG_STATUS) |
                        (avs_address == `RSSQ_REG_WATCHDOG_CONTROL_REG) |
                        (avs_address == `RSSQ_REG_OSCILLATOR_CONTROL_REG);
  wire   wr_take      = avs_write & bus_ack & avs_byteenable[0];

  // merge byte 0 of a write into an 8-bit register
  function automatic logic [7:0] wr_byte(input logic [7:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] be);
    wr_byte = be[0] ? wd[7:0] : old;
  endfunction

  // ----------------------------------------------------------------------
  // sequencer next state
  // ----------------------------------------------------------------------
  // start time counts system clocks since the oscillator is still waking;
  // the 13-bit hold count covers the long crystal hold with room to spare
  always_comb begin
    next_state       = state;
    next_hold_count  = hold_count;
    next_start_count = start_count;
    case (state)
      RSSQ_ST_OSC_START: begin
        if (!supply_good) begin
          next_start_count = '0;
        end else if (start_count == 8'(`RSSQ_OSC_START_CYC - 1)) begin
          next_state      = RSSQ_ST_HOLD;
          next_hold_count = '0;
        end else begin
          next_start_count = start_count + 8'd1;
        end
      end
      RSSQ_ST_HOLD: begin
        if (new_source) begin
          next_state       = RSSQ_ST_OSC_START;
          next_start_count = '0;
        end else if (ipo_tick) begin
          if (hold_count == hold_target) begin
            next_state = RSSQ_ST_PIN_WAIT;
          end else begin
            next_hold_count = hold_count + 13'd1;
          end
        end
      end
      RSSQ_ST_PIN_WAIT: begin
        if (new_source) begin
          next_state       = RSSQ_ST_OSC_START;
          next_start_count = '0;
        end else if (reset_pin_in) begin
          next_state = RSSQ_ST_VEC_HI;
        end
      end
      RSSQ_ST_VEC_HI: begin
        if (prog_valid) begin
          next_state = RSSQ_ST_VEC_LO;
        end
      end
      RSSQ_ST_VEC_LO: begin
        if (prog_valid) begin
          next_state = RSSQ_ST_ACTIVE;
        end
      end
      RSSQ_ST_ACTIVE: begin
        if (stop_instr) begin
          next_state = RSSQ_ST_STOP;
        end else if (halt_instr) begin
          next_state = RSSQ_ST_HALT;
        end
      end
      RSSQ_ST_HALT: begin
        if (interrupt_event) begin
          next_state = RSSQ_ST_ACTIVE;
        end
      end
      RSSQ_ST_STOP: begin
        if (wake_event) begin
          next_state       = RSSQ_ST_OSC_START;
          next_start_count = '0;
        end
      end
      default: begin
        next_state = RSSQ_ST_OSC_START;
      end
    endcase
    if (new_source && !in_reset) begin
      next_state       = RSSQ_ST_OSC_START;
      next_start_count = '0;
    end
  end

  // ----------------------------------------------------------------------
  // sequencer registers
  // ----------------------------------------------------------------------
  // the pin only stretches the hold; it does not restart the sequence
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state       <= RSSQ_ST_OSC_START;
      hold_count  <= '0;
      start_count <= '0;
    end else begin
      state       <= next_state;
      hold_count  <= next_hold_count;
      start_count <= next_start_count;
    end
  end

  // remember whether this sequence is a stop recovery
  // cleared once active, so a later system reset is never taken for one
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      from_stop <= 1'b0;
    end else if (in_stop && wake_event && !new_source) begin
      from_stop <= 1'b1;
    end else if (new_source || state == RSSQ_ST_ACTIVE) begin
      from_stop <= 1'b0;
    end
  end

  // vector high byte capture
  // no retry: the byte is taken on the first valid strobe
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      vec_hi <= 8'h00;
    end else if (state == RSSQ_ST_VEC_HI && prog_valid) begin
      vec_hi <= prog_data;
    end
  end

  // load program counter
  // pc_load is a one-cycle strobe; the value stands until the next load
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pc_load_value <= 16'h0000;
      pc_load       <= 1'b0;
    end else begin
      pc_load <= (state == RSSQ_ST_VEC_LO) && prog_valid;
      if (state == RSSQ_ST_VEC_LO && prog_valid) begin
        pc_load_value <= {vec_hi, prog_data};
      end
    end
  end

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  // defined reset values
  // writes are dropped while in reset; the reload wins every cycle there
  // stop recovery reinitialises watchdog and oscillator control only
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      watchdog_control_reg   <= `RSSQ_WATCHDOG_CONTROL_REG_RESET;
      oscillator_control_reg <= `RSSQ_OSCILLATOR_CONTROL_REG_RESET;
    end else if (in_reset) begin
      watchdog_control_reg   <= `RSSQ_WATCHDOG_CONTROL_REG_RESET;
      oscillator_control_reg <= `RSSQ_OSCILLATOR_CONTROL_REG_RESET;
    end else if (wr_take && avs_address == `RSSQ_REG_WATCHDOG_CONTROL_REG) begin
      watchdog_control_reg <= wr_byte(watchdog_control_reg, avs_writedata,
                                      avs_byteenable);
    end else if (wr_take && avs_address == `RSSQ_REG_OSCILLATOR_CONTROL_REG) begin
      oscillator_control_reg <= wr_byte(oscillator_control_reg,
                                        avs_writedata, avs_byteenable);
    end
  end

  // power control survives stop recovery, not system reset
  // pin mode and clock select reset here
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      power_control_reg <= `RSSQ_PWR_CTL_RESET;
      pin_reset_mode    <= 1'b1;
      sw_clk_select     <= 1'b0;
    end else if (in_reset && !from_stop) begin
      power_control_reg <= `RSSQ_PWR_CTL_RESET;
      pin_reset_mode    <= 1'b1;
      sw_clk_select     <= 1'b0;
    end else if (wr_take && avs_address == `RSSQ_REG_CTRL) begin
      power_control_reg <= avs_writedata[7:0];
      pin_reset_mode    <= ~avs_writedata[8];
      sw_clk_select     <= avs_writedata[9];
    end
  end

  // ----------------------------------------------------------------------
  // avalon slave: one wait cycle, then acknowledge
  // ----------------------------------------------------------------------
  // one wait state lets read data come from a flop; every access takes two
  // cycles, so back-to-back requests run at half the clock rate
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= bus_req & ~bus_ack;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      avs_readdata     <= 32'h0000_0000;
      avs_response_err <= 1'b0;
    end else if (bus_req && !bus_ack) begin
      avs_response_err <= ~addr_ok;
      case (avs_address)
        `RSSQ_REG_CTRL:    avs_readdata <= {22'h0, sw_clk_select,
                                            ~pin_reset_mode,
                                            power_control_reg};
        `RSSQ_REG_STATUS:  avs_readdata <= {25'h0, from_stop, 3'(state),
                                            in_stop, in_halt, in_reset};
        `RSSQ_REG_WATCHDOG_CONTROL_REG: avs_readdata <= {24'h0, watchdog_control_reg};
        `RSSQ_REG_OSCILLATOR_CONTROL_REG: avs_readdata <= {24'h0, oscillator_control_reg};
        default:           avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  assign avs_waitrequest = bus_req & ~bus_ack;

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // vector fetch address
  assign fetch.req  = (state == RSSQ_ST_VEC_HI) | (state == RSSQ_ST_VEC_LO);
  assign fetch.addr = (state == RSSQ_ST_VEC_LO) ? `RSSQ_VEC_LO_ADDR
                                                : `RSSQ_VEC_HI_ADDR;

  // core and peripherals idle in reset
  assign core_reset   = in_reset | fetch.req;
  assign periph_reset = in_reset & ~from_stop;
  // general pins to input, pull-ups off
  assign gpio_reset   = in_reset & ~from_stop;
  // open-drain reset pin driven low
  // released for the pin wait so an outside hold can be seen at all
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe  = pin_reset_mode & port_reset;
  // crystal pins revert to port in stop
  assign crystal_pins_to_port = in_stop;
  // internal oscillator after reset
  // the vector fetch also runs on it, even if software had chosen another
  // source before STOP and the choice survives the recovery
  assign sysclk_is_ipo = ~sw_clk_select | core_reset;

  // core halted in STOP; only core off in HALT
  // active runs everything software leaves on
  // peripherals wait for the vector too, so none runs ahead of the core
  assign power.core_run   = (state == RSSQ_ST_ACTIVE);
  assign power.periph_run = ~in_stop & ~core_reset;
  // internal and crystal oscillators stop in STOP; crystal keeps running in reset
  assign power.ipo_run    = ~in_stop;
  assign power.xtal_run   = ~in_stop;
  assign power.wdt_osc_run = ~in_stop |
                             oscillator_control_reg[`RSSQ_OSC_WDT_EN_BIT];
  // logic follows its own enable only; that enable is cleared by every
  // reset, so the watchdog never counts during the hold
  assign power.wdt_run    = watchdog_control_reg[`RSSQ_WDT_EN_BIT];
  assign power.brownout_run = ~in_stop | opt_brownout_in_stop;
  assign power.amp_run    = power_control_reg[`RSSQ_PWR_AMP_EN_BIT] &
                            ~in_reset;

endmodule

// *** tb/rssq_properties.sv ***
// Purpose : port-level properties of the reset/stop sequencer
// Assumes : bench keeps reset pin and supply quiet while in STOP
// Notes   : bound to rssq_sequencer after the module
`timescale 1ns/100ps
module rssq_properties
  import rssq_pkg::*;
(
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        reset_pin_in,
  input wire logic        opt_brownout_in_stop,
  input wire logic        stop_instr,
  input wire logic        halt_instr,
  input wire logic        wake_event,
  input wire logic [7:0]  prog_data,
  input wire logic        prog_valid,
  input wire rssq_fetch_t fetch,
  input wire logic [15:0] pc_load_value,
  input wire logic        pc_load,
  input wire logic        core_reset,
  input wire logic        reset_pin_out,
  input wire logic        reset_pin_oe,
  input wire logic        crystal_pins_to_port,
  input wire logic        sysclk_is_ipo,
  input wire rssq_power_t power
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // reset phase
  // ----------------------------------------------------------------
  property p_pin_od;
    reset_pin_oe |-> !reset_pin_out;
  endproperty
  a_pin_od: assert property (p_pin_od) else $error("pin driven high");
  property p_core_idle;
    core_reset |-> !power.core_run && !power.periph_run;
  endproperty
  a_core_idle: assert property (p_core_idle) else $error("busy in reset");
  property p_clk_ipo;
    core_reset |-> sysclk_is_ipo;
  endproperty
  a_clk_ipo: assert property (p_clk_ipo) else $error("clock not ipo");
  property p_pin_hold;
    core_reset && !reset_pin_in |=> core_reset;
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("left reset early");
  property p_vec_order;
    fetch.req && fetch.addr == 16'h0002 && prog_valid
      |=> fetch.req && fetch.addr == 16'h0003;
  endproperty
  a_vec_order: assert property (p_vec_order) else $error("vector order");
  property p_vec_load;
    fetch.req && fetch.addr == 16'h0003 && prog_valid
      |=> pc_load && !core_reset && pc_load_value[7:0] == $past(prog_data);
  endproperty
  a_vec_load: assert property (p_vec_load) else $error("vector load");

  // ----------------------------------------------------------------
  // low-power modes
  // ----------------------------------------------------------------
  property p_stop_entry;
    !core_reset && power.core_run && stop_instr |=> crystal_pins_to_port;
  endproperty
  a_stop_entry: assert property (p_stop_entry) else $error("no stop");
  property p_stop_off;
    crystal_pins_to_port |-> !power.core_run && !power.periph_run
      && !power.ipo_run && !power.xtal_run;
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("stop leak");
  property p_stop_stay;
    crystal_pins_to_port && !wake_event |=> crystal_pins_to_port;
  endproperty
  a_stop_stay: assert property (p_stop_stay) else $error("stop left");
  property p_bo_stop;
    crystal_pins_to_port |-> power.brownout_run == opt_brownout_in_stop;
  endproperty
  a_bo_stop: assert property (p_bo_stop) else $error("brownout in stop");
  property p_wake;
    crystal_pins_to_port && wake_event |=> core_reset && !crystal_pins_to_port;
  endproperty
  a_wake: assert property (p_wake) else $error("bad stop recovery");
  property p_halt;
    !core_reset && power.core_run && halt_instr && !stop_instr
      |=> !power.core_run && power.periph_run && !crystal_pins_to_port;
  endproperty
  a_halt: assert property (p_halt) else $error("bad halt");
  c_load: cover property (pc_load);
  c_stop: cover property (crystal_pins_to_port && wake_event);
  c_halt: cover property (power.periph_run && !power.core_run);
endmodule

bind rssq_sequencer rssq_properties chk (
  .clock(clock), .reset(reset), .reset_pin_in(reset_pin_in),
  .opt_brownout_in_stop(opt_brownout_in_stop), .stop_instr(stop_instr),
  .halt_instr(halt_instr), .wake_event(wake_event),
  .prog_data(prog_data), .prog_valid(prog_valid), .fetch(fetch),
  .pc_load_value(pc_load_value), .pc_load(pc_load),
  .core_reset(core_reset), .reset_pin_out(reset_pin_out),
  .reset_pin_oe(reset_pin_oe), .crystal_pins_to_port(crystal_pins_to_port),
  .sysclk_is_ipo(sysclk_is_ipo), .power(power));

// *** tb/rssq_partner.sv ***
// Purpose : program memory model answering the reset vector fetch
// Assumes : one byte per request, random latency of 0 to 3 cycles
// Notes   : data is junk that flips every cycle when not answering
`timescale 1ns/100ps
module rssq_partner
  import rssq_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire rssq_fetch_t fetch,
  input  wire logic [15:0] vector,
  output logic      [7:0]  prog_data,
  output logic             prog_valid
);
  logic [1:0] wait_cnt;
  // high byte at 0002H, low at 0003H
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wait_cnt   <= 2'd1;
      prog_valid <= 1'b0;
      prog_data  <= 8'h5a;
    end else begin
      prog_valid <= 1'b0;
      prog_data  <= ~prog_data;
      if (fetch.req && !prog_valid) begin
        if (wait_cnt != 2'd0) begin
          wait_cnt <= wait_cnt - 2'd1;
        end else begin
          prog_valid <= 1'b1;
          wait_cnt   <= 2'($urandom_range(0, 3));
          if (fetch.addr == 16'h0002) prog_data <= vector[15:8];
          if (fetch.addr == 16'h0003) prog_data <= vector[7:0];
        end
      end
    end
  end
endmodule

// *** tb/test_reset_and_stop_mode_sequencer.sv ***
// Purpose : self-checking bench for the reset/stop sequencer
// Assumes : ipo_tick every 4th clock, reset pin pulled up
// Notes   : hold lengths checked inside a small window for tick phase
`timescale 1ns/100ps
`include "rssq_params.svh"
module test_reset_and_stop_mode_sequencer;
  import rssq_pkg::*;
  logic clock = 0, reset = 1, ipo_tick = 0, supply_good = 1, lv_rst = 0;
  logic ext_low = 0, xtal = 0, bo = 0, stop_i = 0, halt_i = 0, wake = 0;
  logic irq = 0, rd = 0, wr = 0, err, pc_load, core_reset, gpio_reset;
  logic pin_out, pin_oe, xpins, clk_ipo, valid, perr, prst;
  logic [3:0] addr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [15:0] vector = 0, pc_val;
  logic [7:0] pdata;
  logic [1:0] tick_cnt = 0;
  rssq_fetch_t fetch;
  rssq_power_t power;
  int n_fail = 0, n_tests = 0;
  // open-drain pin with pull-up, either party may pull low
  wire pin_in = !(ext_low || (pin_oe && !pin_out));

  always #12.5 clock = ~clock;
  // oscillator cycle is four system clocks
  always @(posedge clock) begin
    tick_cnt <= tick_cnt + 2'd1;
    ipo_tick <= (tick_cnt == 2'd3);
  end

  rssq_sequencer uut (.clock(clock), .reset(reset), .ipo_tick(ipo_tick),
    .supply_good(supply_good), .low_voltage_reset(lv_rst),
    .reset_pin_in(pin_in), .opt_xtal_enable(xtal),
    .opt_brownout_in_stop(bo), .stop_instr(stop_i), .halt_instr(halt_i),
    .wake_event(wake), .interrupt_event(irq), .prog_data(pdata),
    .prog_valid(valid), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_byteenable(4'hf), .avs_readdata(rdata),
    .avs_waitrequest(err), .avs_response_err(perr), .fetch(fetch),
    .pc_load_value(pc_val), .pc_load(pc_load), .core_reset(core_reset),
    .periph_reset(prst), .gpio_reset(gpio_reset), .reset_pin_out(pin_out),
    .reset_pin_oe(pin_oe), .crystal_pins_to_port(xpins),
    .sysclk_is_ipo(clk_ipo), .power(power));
  rssq_partner mem (.clock(clock), .reset(reset), .fetch(fetch),
    .vector(vector), .prog_data(pdata), .prog_valid(valid));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic int hold_cyc(input int ticks);
    return `RSSQ_OSC_START_CYC + ticks * 4;
  endfunction
  // one register access; waitrequest is sampled at the rising edge
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clock);
      k++;
    end while (err !== 1'b0 && k < 50);
    q = rdata;
    if (k >= 50) n_fail++;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // cycles until the vector fetch starts, then until the load
  task automatic to_fetch(output int n);
    n = 0;
    while (fetch.req !== 1'b1 && n < 30000) begin
      @(negedge clock);
      n++;
    end
  endtask
  task automatic to_load();
    int k;
    k = 0;
    while (pc_load !== 1'b1 && k < 100) begin
      @(negedge clock);
      k++;
    end
    check(pc_load, 1);
    check(pc_val, vector);
  endtask
  task automatic pulse(input int s);
    @(posedge clock);
    case (s)
      0: halt_i <= 1'b1;
      1: irq <= 1'b1;
      2: stop_i <= 1'b1;
      default: wake <= 1'b1;
    endcase
    @(posedge clock);
    {halt_i, irq, stop_i, wake} <= 4'h0;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clock);
    n_fail++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    logic [31:0] q, c;
    void'($urandom(32'h9f50));
    vector = 16'($urandom);
    c = 32'($urandom) & 32'h0000_00ff;
    repeat (6) @(posedge clock);
    check({gpio_reset, pin_oe, prst}, 3'b111);
    reset <= 1'b0;
    to_fetch(n);
    check(n >= hold_cyc(66) - 4 && n <= hold_cyc(66) + 8, 1);
    to_load();
    check(clk_ipo, 1);
    bus(0, 4'hc, 0, q);
    check(q, 32'h0000_0020);
    bus(0, 4'h8, 0, q);
    check(q, 32'h0000_0000);
    bus(0, 4'h2, 0, q);
    check({perr, q[30:0]}, {1'b1, 31'h0000_0000});
    bus(1, 4'h0, c | 32'h0000_0200, q);
    bus(1, 4'h8, 32'h0000_0080, q);
    bus(1, 4'hc, 32'h0000_0000, q);
    bus(0, 4'h0, 0, q);
    check(q[7:0], c[7:0]);
    check(clk_ipo, 0);
    $display("test reset and registers done");
    pulse(0);
    @(negedge clock);
    check({power.core_run, power.periph_run}, 2'b01);
    pulse(1);
    @(negedge clock);
    check(power.core_run, 1);
    $display("test halt done");
    @(posedge clock);
    bo <= 1'($urandom);
    pulse(2);
    repeat (20) @(negedge clock);
    check(xpins, 1);
    check({power.wdt_osc_run, power.wdt_run}, 2'b01);
    check({power.amp_run, power.brownout_run}, {c[4], bo});
    pulse(3);
    to_fetch(n);
    check(n >= hold_cyc(66) - 4 && n <= hold_cyc(66) + 8, 1);
    to_load();
    bus(0, 4'h0, 0, q);
    check(q[7:0], c[7:0]);
    bus(0, 4'h8, 0, q);
    check(q, 32'h0000_0000);
    bus(0, 4'hc, 0, q);
    check(q, 32'h0000_0020);
    $display("test stop recovery done");
    lv_rst <= 1'b1;
    ext_low <= 1'b1;
    repeat (3) @(posedge clock);
    lv_rst <= 1'b0;
    repeat (700) @(negedge clock);
    check({core_reset, fetch.req}, 2'b10);
    @(posedge clock);
    ext_low <= 1'b0;
    to_fetch(n);
    to_load();
    check(clk_ipo, 1);
    $display("test pin held done");
    @(posedge clock);
    xtal <= 1'b1;
    supply_good <= 1'b0;
    reset <= 1'b1;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    repeat (40) @(posedge clock);
    supply_good <= 1'b1;
    to_fetch(n);
    check(n >= hold_cyc(5000) - 4 && n <= hold_cyc(5000) + 8, 1);
    to_load();
    $display("test crystal hold done");
    wrap_up();
  end
endmodule
